// File: core/scs_div.v
// enable pulse divider for the sample rate and the window tick
`timescale 1ns/10ps
module scs_div #(
	parameter integer DIV = 4
) (
	input  wire pclk,
	input  wire presetn,
	input  wire run,
	output reg  pulse
);
	reg [31:0] cnt_r;

	// free count, one pulse each DIV cycles while running
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
			pulse <= 1'b0;
		end else if (!run) begin
			cnt_r <= 32'h0;
			pulse <= 1'b0;
		end else if (cnt_r == DIV - 1) begin
			cnt_r <= 32'h0;
			pulse <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
			pulse <= 1'b0;
		end
	end
endmodule // scs_div

// File: core/scs_map.vh
// register map, field positions, reset values and timing counts of the step block
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// apb byte offsets
`define SCS_OFS_PAGE        8'h00
`define SCS_OFS_ENABLE      8'h04
`define SCS_OFS_INIT        8'h08
`define SCS_OFS_PIN1_ROUTE  8'h0c
`define SCS_OFS_PIN2_ROUTE  8'h10
`define SCS_OFS_LATCH       8'h14
`define SCS_OFS_STATUS      8'h18
`define SCS_OFS_SOURCE      8'h1c
`define SCS_OFS_COUNT_L     8'h20
`define SCS_OFS_COUNT_H     8'h24
`define SCS_OFS_DEBOUNCE    8'h28
`define SCS_OFS_WIN_L       8'h2c
`define SCS_OFS_WIN_H       8'h30
`define SCS_OFS_CMD         8'h34
`define SCS_OFS_MIRROR      8'h38
`define SCS_OFS_MD1         8'h3c
`define SCS_OFS_MD2         8'h40
`define SCS_OFS_TIMER       8'h44
`define SCS_OFS_ACCEL       8'h48

// page access code
`define SCS_PAGE_EMB        8'h80

// field positions
`define SCS_B_STEP_EN       3
`define SCS_B_SIGMOT_EN     5
`define SCS_B_STEP_RT       3
`define SCS_B_SIGMOT_RT     5
`define SCS_B_LATCH         7
`define SCS_B_IS_STEP       3
`define SCS_B_SIGMOTION_EVENT_BIT     5
`define SCS_B_CLEAR         7
`define SCS_B_DETECTED      5
`define SCS_B_WIN_FLAG      4
`define SCS_B_OVERFLOW      3
`define SCS_B_INC_FLAG      2
`define SCS_B_CARRY_EN      4
`define SCS_B_EMB_RT        1
`define SCS_B_TS_EN         5

// reset values and the significant motion step threshold
`define SCS_RST_DEBOUNCE    8'h0a
`define SCS_SIGMOT_STEPS    8'h0a

// timing: 26 hz sample, 6.4 ms window tick, 1.2 s idle
`define SCS_CLK_HZ          200000000
`define SCS_SAMPLE_HZ       26
`define SCS_TICK_US         6400
`define SCS_IDLE_MS         1200
`define SCS_SAMPLE_CYC      (`SCS_CLK_HZ / `SCS_SAMPLE_HZ)
`define SCS_TICK_CYC        (`SCS_CLK_HZ / 1000000 * `SCS_TICK_US)
`define SCS_IDLE_SAMPLES    ((`SCS_IDLE_MS * `SCS_SAMPLE_HZ + 999) / 1000)

`endif

// File: core/scs_step.v
// step counter and significant motion logic with apb register port
//
// Contract
// R01: step logic runs on accel samples at 26 hz; host sets rate >= 26 hz
// R02: step functions run only when enabled; init bit resets detection state
// R03: step count is a 16-bit value read as low and high bytes
// R04: count survives disable and init; clear bit 7 clears it, self-returns
// R05: debounce steps needed before first increment; no event before then
// R06: after 1.2 s without steps the debounce restarts
// R07: step detected bit 5 set for each debounced step
// R08: window flag bit 4 set at period end if a step was counted
// R09: host enables timer; window flag held 0 while period is zero
// R10: overflow bit 3 rises when count reaches 2^16
// R11: increment bit 2 set on count increase, held 0 with window period
// R12: step event follows overflow, window flag or increment flag by config
// R13: events reach a pin only with function and global route bits set
// R14: default events are pulses of one 26 hz sample period; a step event from the overflow source stays high until the count is cleared
// R15: latched mode holds event until host reads its status bit
// R16: step event readable in embedded status and main page mirror
// R17: significant motion fires after more than 10 steps, then resets
// R18: significant motion runs when enabled; its init bit reinitialises it
// R19: significant motion enable also runs the step algorithm
// R20: host writes 80h to page register for embedded access, 00h after
// R21: host sequence for latched significant motion on pin one
// R22: counter wraps to zero past maximum, overflow flag records it
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "scs_map.vh"
module scs_step #(
	parameter integer SAMPLE_CYC  = `SCS_SAMPLE_CYC,
	parameter integer TICK_CYC    = `SCS_TICK_CYC,
	parameter integer IDLE_SAMPLES = `SCS_IDLE_SAMPLES
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        step_raw,
	output wire        irq_pin_one,
	output wire        irq_pin_two
);
	////////////////////////////////////////////////////////////////////////////
	// registers
	reg  [7:0]  page_access_reg_r;
	reg  [7:0]  embedded_enable_reg_r;
	reg  [7:0]  embedded_pin_one_route_reg_r;
	reg  [7:0]  embedded_pin_two_route_reg_r;
	reg         embedded_latch_enable_r;
	reg  [7:0]  debounce_config_reg_r;
	reg  [15:0] window_period_r;
	reg         carry_count_en_r;
	reg  [7:0]  pin_one_routing_reg_r;
	reg  [7:0]  pin_two_routing_reg_r;
	reg  [7:0]  timer_control_reg_r;
	reg  [7:0]  accel_control_reg_r;
	reg  [15:0] step_count_r;
	reg         overflow_r;
	reg         detected_r;
	reg         inc_flag_r;
	reg         window_step_flag_r;
	reg         win_seen_r;
	reg  [15:0] win_ticks_r;
	reg  [7:0]  deb_left_r;
	reg  [7:0]  idle_cnt_r;
	reg  [4:0]  sigmot_cnt_r;
	reg         step_ev_r;
	reg         sigmot_ev_r;
	reg         step_sync1_r;
	reg         step_sync2_r;
	reg         step_pend_r;
	reg         step_sync3_r;
	reg         step_src_d_r;

	wire        wr_en  = psel & penable & pwrite;
	wire        rd_en  = psel & penable & ~pwrite;
	wire        emb    = (page_access_reg_r == `SCS_PAGE_EMB);
	wire        step_en   = embedded_enable_reg_r[`SCS_B_STEP_EN];
	wire        sigmot_en = embedded_enable_reg_r[`SCS_B_SIGMOT_EN];
	wire        algo_run  = step_en | sigmot_en; // R19
	wire        win_on    = (window_period_r != 16'h0);
	wire        sample_en;
	wire        tick_en;

	// apb answers in the access cycle with no wait state
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// bus write/read helpers
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// sample and window tick dividers
	scs_div #(.DIV(SAMPLE_CYC)) u_sample (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (algo_run),
		.pulse   (sample_en)
	); // R01

	scs_div #(.DIV(TICK_CYC)) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (win_on & timer_control_reg_r[`SCS_B_TS_EN]),
		.pulse   (tick_en)
	); // R09

	////////////////////////////////////////////////////////////////////////////
	// step input from the recogniser pin: two-stage sync, then one step per rising
	// edge, held until the next sample; a long pulse must not count twice
	wire step_rise = step_sync2_r & ~step_sync3_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_sync1_r <= 1'b0;
			step_sync2_r <= 1'b0;
			step_sync3_r <= 1'b0;
			step_pend_r  <= 1'b0;
		end else begin
			step_sync1_r <= step_raw;
			step_sync2_r <= step_sync1_r;
			step_sync3_r <= step_sync2_r;
			// steps seen while stopped are dropped, not replayed on enable
			if (!algo_run)
				step_pend_r <= 1'b0;
			else if (sample_en)
				step_pend_r <= step_rise;
			else if (step_rise)
				step_pend_r <= 1'b1;
		end
	end

	wire init_step = wr_en & emb & hit(paddr, `SCS_OFS_INIT) & pwdata[`SCS_B_STEP_EN];
	wire init_sig  = wr_en & emb & hit(paddr, `SCS_OFS_INIT) & pwdata[`SCS_B_SIGMOT_EN];
	wire clr_cnt   = wr_en & emb & hit(paddr, `SCS_OFS_SOURCE) & pwdata[`SCS_B_CLEAR];
	wire step_now  = sample_en & step_pend_r & algo_run;
	wire counted   = step_now & (deb_left_r <= 8'h1); // the step ending debounce counts too
	wire [16:0] cnt_sum = {1'b0, step_count_r} + 17'h1;

	////////////////////////////////////////////////////////////////////////////
	// debounce, idle timer and step counter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_left_r   <= `SCS_RST_DEBOUNCE;
			idle_cnt_r   <= 8'h0;
			step_count_r <= 16'h0;
			overflow_r   <= 1'b0;
			detected_r   <= 1'b0;
			inc_flag_r   <= 1'b0;
		end else begin
			if (sample_en) begin
				detected_r <= 1'b0;
				inc_flag_r <= 1'b0;
			end
			if (init_step) begin
				deb_left_r <= debounce_config_reg_r; // R02
				idle_cnt_r <= 8'h0;
			end else if (step_now) begin
				idle_cnt_r <= 8'h0;
				if (deb_left_r > 8'h1)
					deb_left_r <= deb_left_r - 8'h1; // R05
				else
					deb_left_r <= 8'h0;
			end else if (sample_en) begin
				if (idle_cnt_r >= IDLE_SAMPLES - 1) begin
					deb_left_r <= debounce_config_reg_r; // R06
					idle_cnt_r <= 8'h0;
				end else begin
					idle_cnt_r <= idle_cnt_r + 8'h1;
				end
			end
			// count on the step that completes debounce as well
			if (clr_cnt) begin
				step_count_r <= 16'h0; // R04
				overflow_r   <= 1'b0;
			end else if (counted) begin
				step_count_r <= cnt_sum[15:0]; // R22
				if (cnt_sum[16])
					overflow_r <= 1'b1; // R10
				detected_r <= 1'b1; // R07
				inc_flag_r <= ~win_on; // R11
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// window period flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_ticks_r        <= 16'h0;
			win_seen_r         <= 1'b0;
			window_step_flag_r <= 1'b0;
		end else if (!win_on) begin
			win_ticks_r        <= 16'h0;
			win_seen_r         <= 1'b0;
			window_step_flag_r <= 1'b0; // R09
		end else begin
			if (sample_en)
				window_step_flag_r <= 1'b0;
			if (tick_en & (win_ticks_r >= window_period_r - 16'h1)) begin
				win_ticks_r        <= 16'h0;
				window_step_flag_r <= win_seen_r | counted; // R08
				win_seen_r         <= 1'b0;
			end else begin
				if (tick_en)
					win_ticks_r <= win_ticks_r + 16'h1;
				if (counted)
					win_seen_r <= 1'b1;
			end
		end
	end

	// step event source selection
	wire step_src = carry_count_en_r ? overflow_r :
	                win_on ? window_step_flag_r : inc_flag_r; // R12
	wire step_fire = step_src & ~step_src_d_r;
	wire sig_hit   = sigmot_en & counted & (sigmot_cnt_r >= `SCS_SIGMOT_STEPS); // R17
	wire rd_status = rd_en & ((emb & hit(paddr, `SCS_OFS_STATUS)) | hit(paddr, `SCS_OFS_MIRROR));

	////////////////////////////////////////////////////////////////////////////
	// significant motion counter and event bits (pulse or latch)
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sigmot_cnt_r <= 5'h0;
			sigmot_ev_r  <= 1'b0;
			step_ev_r    <= 1'b0;
			step_src_d_r <= 1'b0;
		end else begin
			if (init_sig | ~sigmot_en | sig_hit)
				sigmot_cnt_r <= 5'h0; // R18
			else if (counted)
				sigmot_cnt_r <= sigmot_cnt_r + 5'h1;
			// set wins over the read clear
			if (sig_hit)
				sigmot_ev_r <= 1'b1;
			else if (embedded_latch_enable_r ? rd_status : sample_en)
				sigmot_ev_r <= 1'b0; // R14 R15
			step_src_d_r <= step_src;
			// latch on the source's rising edge so a read inside the sample
			// period does not re-arm the pin at once
			if (embedded_latch_enable_r) begin
				if (step_fire)
					step_ev_r <= 1'b1;
				else if (rd_status)
					step_ev_r <= 1'b0; // R15
			end else begin
				step_ev_r <= step_src; // R14
			end
		end
	end

	// pin routing needs both function and global route bits
	assign irq_pin_one = pin_one_routing_reg_r[`SCS_B_EMB_RT] &
		((step_ev_r & embedded_pin_one_route_reg_r[`SCS_B_STEP_RT]) |
		 (sigmot_ev_r & embedded_pin_one_route_reg_r[`SCS_B_SIGMOT_RT])); // R13
	assign irq_pin_two = pin_two_routing_reg_r[`SCS_B_EMB_RT] &
		((step_ev_r & embedded_pin_two_route_reg_r[`SCS_B_STEP_RT]) |
		 (sigmot_ev_r & embedded_pin_two_route_reg_r[`SCS_B_SIGMOT_RT])); // R13

	////////////////////////////////////////////////////////////////////////////
	// apb register writes; embedded page only when page code is set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_access_reg_r            <= 8'h0;
			embedded_enable_reg_r        <= 8'h0;
			embedded_pin_one_route_reg_r <= 8'h0;
			embedded_pin_two_route_reg_r <= 8'h0;
			embedded_latch_enable_r      <= 1'b0;
			debounce_config_reg_r        <= `SCS_RST_DEBOUNCE;
			window_period_r              <= 16'h0;
			carry_count_en_r             <= 1'b0;
			pin_one_routing_reg_r        <= 8'h0;
			pin_two_routing_reg_r        <= 8'h0;
			timer_control_reg_r          <= 8'h0;
			accel_control_reg_r          <= 8'h0;
		end else if (wr_en) begin
			if (hit(paddr, `SCS_OFS_PAGE))
				page_access_reg_r <= pwdata[7:0];
			if (hit(paddr, `SCS_OFS_MD1))
				pin_one_routing_reg_r <= pwdata[7:0];
			if (hit(paddr, `SCS_OFS_MD2))
				pin_two_routing_reg_r <= pwdata[7:0];
			if (hit(paddr, `SCS_OFS_TIMER))
				timer_control_reg_r <= pwdata[7:0];
			if (hit(paddr, `SCS_OFS_ACCEL))
				accel_control_reg_r <= pwdata[7:0];
			if (emb) begin
				if (hit(paddr, `SCS_OFS_ENABLE))
					embedded_enable_reg_r <= pwdata[7:0]; // R02 R18
				if (hit(paddr, `SCS_OFS_PIN1_ROUTE))
					embedded_pin_one_route_reg_r <= pwdata[7:0];
				if (hit(paddr, `SCS_OFS_PIN2_ROUTE))
					embedded_pin_two_route_reg_r <= pwdata[7:0];
				if (hit(paddr, `SCS_OFS_LATCH))
					embedded_latch_enable_r <= pwdata[`SCS_B_LATCH];
				if (hit(paddr, `SCS_OFS_DEBOUNCE))
					debounce_config_reg_r <= pwdata[7:0];
				if (hit(paddr, `SCS_OFS_WIN_L))
					window_period_r[7:0] <= pwdata[7:0];
				if (hit(paddr, `SCS_OFS_WIN_H))
					window_period_r[15:8] <= pwdata[7:0];
				if (hit(paddr, `SCS_OFS_CMD))
					carry_count_en_r <= pwdata[`SCS_B_CARRY_EN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux; clear bit always reads 0 since clearing is done in one cycle
	wire [7:0] src_byte = {1'b0, 1'b0, detected_r, window_step_flag_r,
	                       overflow_r, inc_flag_r, 2'b00};
	wire [7:0] stat_byte = {2'b00, sigmot_ev_r, 1'b0, step_ev_r, 3'b000}; // R16

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= 32'h0;
			case (paddr)
			`SCS_OFS_PAGE:   prdata[7:0] <= page_access_reg_r;
			`SCS_OFS_MD1:    prdata[7:0] <= pin_one_routing_reg_r;
			`SCS_OFS_MD2:    prdata[7:0] <= pin_two_routing_reg_r;
			`SCS_OFS_TIMER:  prdata[7:0] <= timer_control_reg_r;
			`SCS_OFS_ACCEL:  prdata[7:0] <= accel_control_reg_r;
			`SCS_OFS_MIRROR: prdata[7:0] <= stat_byte; // R16
			default: begin
				if (emb) begin
					case (paddr)
					`SCS_OFS_ENABLE:     prdata[7:0] <= embedded_enable_reg_r;
					`SCS_OFS_PIN1_ROUTE: prdata[7:0] <= embedded_pin_one_route_reg_r;
					`SCS_OFS_PIN2_ROUTE: prdata[7:0] <= embedded_pin_two_route_reg_r;
					`SCS_OFS_LATCH:      prdata[7:0] <= {embedded_latch_enable_r, 7'h0};
					`SCS_OFS_STATUS:     prdata[7:0] <= stat_byte;
					`SCS_OFS_SOURCE:     prdata[7:0] <= src_byte;
					`SCS_OFS_COUNT_L:    prdata[7:0] <= step_count_r[7:0]; // R03
					`SCS_OFS_COUNT_H:    prdata[7:0] <= step_count_r[15:8]; // R03
					`SCS_OFS_DEBOUNCE:   prdata[7:0] <= debounce_config_reg_r;
					`SCS_OFS_WIN_L:      prdata[7:0] <= window_period_r[7:0];
					`SCS_OFS_WIN_H:      prdata[7:0] <= window_period_r[15:8];
					`SCS_OFS_CMD:        prdata[7:0] <= {3'b000, carry_count_en_r, 4'h0};
					default:             prdata[7:0] <= 8'h00;
					endcase
				end
			end
			endcase
		end
	end
endmodule // scs_step

// File: verif/scs_step_sva.sv
// concurrent checks on the apb port and interrupt pins of the step block
`timescale 1ns/10ps
module scs_step_sva #(
	parameter integer SAMPLE_CYC = 20
) (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        irq_pin_one,
	input logic        irq_pin_two
);
	logic [7:0] page_r;
	logic       lir_r, rt1_r, rt2_r, md1_r, md2_r;
	int         hi_r;
	wire        wr_w = psel && penable && pwrite;
	wire        rd_w = psel && penable && !pwrite;
	wire        emb_w = page_r == 8'h80;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// shadow of host writes, so the pin checks need no view inside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{page_r, lir_r, rt1_r, rt2_r, md1_r, md2_r} <= 13'h0;
		end else if (wr_w) begin
			if (paddr == 8'h00) page_r <= pwdata[7:0];
			if (paddr == 8'h14 && emb_w) lir_r <= pwdata[7];
			if (paddr == 8'h0c && emb_w) rt1_r <= pwdata[3] | pwdata[5];
			if (paddr == 8'h10 && emb_w) rt2_r <= pwdata[3] | pwdata[5];
			if (paddr == 8'h3c) md1_r <= pwdata[1];
			if (paddr == 8'h40) md2_r <= pwdata[1];
		end
	end
	// length of the current high stretch on pin one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hi_r <= 0;
		else hi_r <= irq_pin_one ? hi_r + 1 : 0;
	end
	////////////////////////////////////////
	property p_hold; rd_w |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved early");
	property p_upper; psel && penable |-> prdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("read data upper bits set");
	property p_refuse; rd_w && paddr >= 8'h04 && paddr <= 8'h34 && !emb_w |-> prdata == 32'h0;
	endproperty
	a_refuse: assert property (p_refuse) else $error("closed page readable");
	property p_clr; rd_w && paddr == 8'h1c |-> !prdata[7]; endproperty
	a_clr: assert property (p_clr) else $error("clear bit reads one");
	property p_route1; !(rt1_r && md1_r) |-> !irq_pin_one; endproperty
	a_route1: assert property (p_route1) else $error("pin one unrouted yet high");
	property p_route2; !(rt2_r && md2_r) |-> !irq_pin_two; endproperty
	a_route2: assert property (p_route2) else $error("pin two unrouted yet high");
	property p_pulse; !lir_r |-> hi_r <= SAMPLE_CYC; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse longer than a sample");
	property p_latch; lir_r && irq_pin_one && !rd_w && !$past(rd_w) |=> irq_pin_one;
	endproperty
	a_latch: assert property (p_latch) else $error("latched pin dropped unread");
endmodule // scs_step_sva

bind scs_step scs_step_sva #(.SAMPLE_CYC(SAMPLE_CYC)) scs_step_sva_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .irq_pin_one(irq_pin_one),
	.irq_pin_two(irq_pin_two));

// File: verif/scs_walker.sv
// stand-in for the step recogniser that feeds the block step pulses
`timescale 1ns/10ps
module scs_walker #(
	parameter integer GAP = 40
) (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       start,
	input  logic [7:0] nsteps,
	output logic       step_raw,
	output logic       busy
);
	logic [7:0] left_r;
	int         cnt_r;
	////////////////////////////////////////
	// one short pulse per period; a period spans two samples so none merge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= 8'h00;
			cnt_r <= 0;
			step_raw <= 1'b0;
		end else if (start) begin
			left_r <= nsteps;
			cnt_r <= 0;
		end else if (left_r != 8'h00) begin
			step_raw <= cnt_r < 3;
			cnt_r <= (cnt_r == GAP - 1) ? 0 : cnt_r + 1;
			if (cnt_r == GAP - 1) left_r <= left_r - 8'h01;
		end else begin
			step_raw <= 1'b0;
		end
	end
	assign busy = left_r != 8'h00;
endmodule // scs_walker

// File: verif/step_counter_sigmotion_tb.sv
// self-checking bench for the step counter and significant motion block
`timescale 1ns/10ps
module step_counter_sigmotion_tb;
	localparam integer      sc = 20;
	localparam logic [31:0] all_m = 32'hffffffff;
	logic        pclk, presetn, psel, penable, pwrite, start;
	logic [7:0]  paddr, nsteps;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, step_raw, irq_pin_one, irq_pin_two, busy;
	int          mismatches, compares;
	////////////////////////////////////////
	scs_step #(.SAMPLE_CYC(sc), .TICK_CYC(8), .IDLE_SAMPLES(4)) scs_step_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .step_raw(step_raw), .irq_pin_one(irq_pin_one),
		.irq_pin_two(irq_pin_two));
	scs_walker #(.GAP(2 * sc)) scs_walker_inst (.pclk(pclk), .presetn(presetn),
		.start(start), .nsteps(nsteps), .step_raw(step_raw), .busy(busy));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	////////////////////////////////////////
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: reg %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: pin %b want %b", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) chk_pin(1'b0, 1'b1);
		rd = prdata;
		chk_pin(pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_reg(rd & m, e);
	endtask
	// hand n steps to the recogniser and wait until the last is sampled
	task automatic walk(input logic [7:0] n);
		int t;
		@(posedge pclk);
		start <= 1'b1;
		nsteps <= n;
		@(posedge pclk);
		start <= 1'b0;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (busy && t < 5000);
		if (t >= 5000) chk_pin(1'b1, 1'b0);
		repeat (4) @(posedge pclk);
		@(negedge pclk);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		end_of_test();
	end
	initial begin
		mismatches = 0;
		compares = 0;
		{presetn, psel, penable, pwrite, start} = 5'h0;
		{paddr, nsteps, pwdata} = 48'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rc(8'h00, all_m, 32'h0);
		rc(8'h28, all_m, 32'h0);
		rc(8'h4c, all_m, 32'h0);
		wr(8'h00, 32'h80);
		rc(8'h28, all_m, 32'h0a);
		rc(8'h20, all_m, 32'h0);
		$display("test reset done");
		wr(8'h28, 32'h03);
		wr(8'h48, 32'h20);
		wr(8'h3c, 32'h02);
		wr(8'h0c, 32'h08);
		wr(8'h04, 32'h08);
		wr(8'h08, 32'h08);
		walk(8'd2);
		rc(8'h20, all_m, 32'h0);
		walk(8'd1);
		rc(8'h20, all_m, 32'h1);
		walk(8'd2);
		rc(8'h20, all_m, 32'h3);
		rc(8'h24, all_m, 32'h0);
		$display("test debounce done");
		repeat (10 * sc) @(posedge pclk);
		walk(8'd2);
		rc(8'h20, all_m, 32'h3);
		walk(8'd1);
		rc(8'h20, all_m, 32'h4);
		$display("test idle done");
		wr(8'h04, 32'h00);
		walk(8'd1);
		rc(8'h20, all_m, 32'h4);
		wr(8'h08, 32'h08);
		rc(8'h20, all_m, 32'h4);
		wr(8'h04, 32'h08);
		wr(8'h1c, 32'h80);
		rc(8'h20, all_m, 32'h0);
		rc(8'h1c, 32'h80, 32'h0);
		$display("test clear done");
		wr(8'h28, 32'h01);
		wr(8'h08, 32'h08);
		wr(8'h14, 32'h80);
		walk(8'd1);
		chk_pin(irq_pin_one, 1'b1);
		chk_pin(irq_pin_two, 1'b0);
		rc(8'h18, all_m, 32'h08);
		chk_pin(irq_pin_one, 1'b0);
		walk(8'd1);
		rc(8'h38, 32'h08, 32'h08);
		chk_pin(irq_pin_one, 1'b0);
		rc(8'h20, all_m, 32'h2);
		$display("test latch done");
		wr(8'h44, 32'h20);
		wr(8'h2c, 32'h01);
		walk(8'd1);
		chk_pin(irq_pin_one, 1'b1);
		rc(8'h18, all_m, 32'h08);
		wr(8'h2c, 32'h00);
		rc(8'h1c, 32'h10, 32'h0);
		rc(8'h20, all_m, 32'h3);
		$display("test window done");
		wr(8'h04, 32'h20);
		wr(8'h08, 32'h20);
		wr(8'h0c, 32'h20);
		wr(8'h10, 32'h20);
		wr(8'h40, 32'h02);
		walk(8'd10);
		chk_pin(irq_pin_two, 1'b0);
		chk_pin(irq_pin_one, 1'b0);
		rc(8'h20, all_m, 32'hd);
		walk(8'd1);
		chk_pin(irq_pin_two, 1'b1);
		chk_pin(irq_pin_one, 1'b1);
		rc(8'h38, 32'h20, 32'h20);
		chk_pin(irq_pin_two, 1'b0);
		$display("test sigmotion done");
		end_of_test();
	end
endmodule // step_counter_sigmotion_tb
